// ### logic/mcal_pkg.sv
`default_nettype none
package mcal_pkg;
  // ----------------------------------------------------------------
  // Line characters
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] CH_LOW_A = 8'h61;
  localparam logic [7:0] CH_LOW_Z = 8'h7A;
  localparam logic [7:0] CH_CASE_BIT = 8'h20;

  // ----------------------------------------------------------------
  // Keywords, right aligned in a nine byte field
  // ----------------------------------------------------------------
  localparam int KW_BYTES = 9;
  localparam int KW_W = 72;
  localparam logic [71:0] KW_BEGIN = 72'h41_43_51_5F_53_54_41_52_54;
  localparam logic [71:0] KW_FINISH = 72'h00_00_41_43_51_5F_45_4E_44;
  localparam logic [71:0] KW_CLEAR = 72'h41_43_51_5F_52_45_53_45_54;
  localparam logic [71:0] KW_SETDATE = 72'h00_53_45_54_5F_44_41_54_45;
  localparam logic [71:0] KW_GETDATE = 72'h00_47_45_54_5F_44_41_54_45;
  localparam logic [3:0] LEN_BEGIN = 4'h9;
  localparam logic [3:0] LEN_FINISH = 4'h7;
  localparam logic [3:0] LEN_CLEAR = 4'h9;
  localparam logic [3:0] LEN_DATE = 4'h8;

  // ----------------------------------------------------------------
  // Date argument and replies
  // ----------------------------------------------------------------
  localparam logic [3:0] DATE_DIGITS = 4'hE;
  localparam int DIG_W = 56;
  localparam int RESP_W = 200;
  localparam logic [15:0] TXT_OK = 16'h4F_4B;
  localparam logic [47:0] TXT_ERR48 = 48'h45_52_52_2D_34_38;
  localparam logic [4:0] RLEN_OK = 5'h04;
  localparam logic [4:0] RLEN_ERR = 5'h08;
  localparam logic [4:0] RLEN_DATE = 5'h19;

  // ----------------------------------------------------------------
  // Calendar
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int RTC_PERIOD_S = 1;
  localparam int RTC_TICK_CYCLES = CLK_FREQ_HZ * RTC_PERIOD_S;
  localparam logic [11:0] YEAR_RST = 12'h7D0;
  localparam logic [3:0] MON_RST = 4'h1;
  localparam logic [4:0] DAY_RST = 5'h01;
  localparam logic [3:0] MON_FEB = 4'h2;
  localparam logic [3:0] MON_DEC = 4'hC;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [5:0] MINSEC_MAX = 6'h3B;
  localparam logic [4:0] MONTH_DAYS [1:12] = '{5'h1F, 5'h1C, 5'h1F, 5'h1E, 5'h1F, 5'h1E,
                                              5'h1F, 5'h1F, 5'h1E, 5'h1F, 5'h1E, 5'h1F};

  // ----------------------------------------------------------------
  // Conversion results and limits
  // ----------------------------------------------------------------
  localparam int SAMPLE_BITS = 16;
  localparam int SAMPLE_RATE_HZ = 2000;
  localparam int IND_BITS = 32;
  localparam int RATED_BITS = 16;
  localparam int RANGE_TENTHS_MVV = 30;
  localparam int ZERO_TENTHS_MVV = 20;
  localparam int COUNTS_PER_TENTH_DEF = 1092;
  localparam int FULL_LIMIT = 9999;
  localparam int RATED_MAX_UMVV = 3000;

  typedef enum logic [1:0] {MCAL_CAL_NONE, MCAL_CAL_REAL, MCAL_CAL_EQUIV, MCAL_CAL_TEDS} mcal_cal_t;
endpackage : mcal_pkg
`default_nettype wire

// ### logic/mcal_core.sv
// What this block does
// - Measurement commands act only on measurement screen
// - Start without argument begins measurement, replies OK
// - Start while running replies error 48
// - End without argument stops measurement, replies OK
// - End while idle replies error 48
// - Reset acts as screen reset, replies OK
// - Set-date loads calendar from dotted date, time
// - Get-date returns calendar line then OK
// - Positive sensor over-range above 3.0 mV/V
// - Negative sensor over-range past negative limit
// - Positive overflow when indicated value exceeds 9999
// - Negative overflow when indicated value underflows
// - Real-load calibration flags input above 3 mV/V
// - Zero step flags magnitude above 2 mV/V
// - Equivalent calibration refuses rated output above 3
// - TEDS calibration flags missing TEDS sensor
// - Over-range alarms use 16-bit results, overflow alarms 32-bit indicated values, 2000 per second
// - Keywords accepted in either letter case
// - ASCII lines ended by CR or LF
`timescale 1ns/10ps
`default_nettype none
module mcal_core #(
  parameter int TICK_CYCLES = mcal_pkg::RTC_TICK_CYCLES,
  parameter int COUNTS_PER_TENTH = mcal_pkg::COUNTS_PER_TENTH_DEF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Request bytes from the serial receiver
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  // Reply bytes to the serial transmitter
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  // Screen and measurement control
  input wire logic meas_screen_i,
  input wire logic screen_reset_i,
  output logic meas_active_o,
  output logic meas_clear_o,
  // Conversion results
  input wire logic [mcal_pkg::SAMPLE_BITS-1:0] sample_i,
  input wire logic sample_valid_i,
  input wire logic [mcal_pkg::IND_BITS-1:0] ind_value_i,
  input wire logic ind_valid_i,
  // Calibration
  input wire mcal_pkg::mcal_cal_t cal_mode_i,
  input wire logic cal_zero_step_i,
  input wire logic [mcal_pkg::RATED_BITS-1:0] rated_i,
  input wire logic rated_valid_i,
  input wire logic teds_present_i,
  // Alarms and calibration errors
  output logic over_pos_o,
  output logic over_neg_o,
  output logic full_pos_o,
  output logic full_neg_o,
  output logic err_range_o,
  output logic err_zero_o,
  output logic err_input_over_o,
  output logic err_teds_o,
  output logic rated_accept_o
);
  import mcal_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int TW = $clog2(TICK_CYCLES);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam logic signed [31:0] RANGE_LIM = 32'(RANGE_TENTHS_MVV * COUNTS_PER_TENTH);
  localparam logic signed [31:0] ZERO_LIM = 32'(ZERO_TENTHS_MVV * COUNTS_PER_TENTH);
  localparam logic signed [31:0] FULL_LIM = 32'(FULL_LIMIT);
  localparam logic [RATED_BITS-1:0] RATED_LIM = RATED_BITS'(RATED_MAX_UMVV);

  typedef enum logic [1:0] {MCAL_RECV, MCAL_EXEC, MCAL_SEND} mcal_state_t;

  typedef struct packed {
    mcal_state_t state;
    logic [KW_W-1:0] kw;
    logic [3:0] kw_len;
    logic in_arg;
    logic arg_seen;
    logic bad_arg;
    logic [DIG_W-1:0] digits;
    logic [3:0] dig_cnt;
    logic [RESP_W-1:0] resp;
    logic [4:0] resp_len;
    logic [7:0] tx_data;
    logic tx_valid;
    logic rx_ready;
    logic active;
    logic clear;
    logic [11:0] year;
    logic [3:0] mon;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
    logic [TW-1:0] tick;
    logic over_pos;
    logic over_neg;
    logic full_pos;
    logic full_neg;
    logic err_range;
    logic err_zero;
    logic err_over;
    logic err_teds;
    logic rated_ok;
    logic [1:0] teds_sync;
  } mcal_regs_t;

  localparam mcal_regs_t REGS_RST = '{state: MCAL_RECV, rx_ready: 1'b1, year: YEAR_RST, mon: MON_RST,
                                      day: DAY_RST, default: '0};

  mcal_regs_t st_q;
  mcal_regs_t st_d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // case folding
  function automatic logic [7:0] upcase(input logic [7:0] c);
    upcase = (c >= CH_LOW_A && c <= CH_LOW_Z) ? (c & ~CH_CASE_BIT) : c;
  endfunction : upcase

  function automatic logic [3:0] dig(input logic [DIG_W-1:0] d, input int i);
    dig = d[DIG_W-1-4*i -: 4];
  endfunction : dig

  function automatic logic [15:0] asc2(input logic [6:0] v);
    asc2 = {8'(CH_ZERO + 8'(v / 7'd10)), 8'(CH_ZERO + 8'(v % 7'd10))};
  endfunction : asc2

  function automatic logic [4:0] days_in(input logic [3:0] m, input logic [11:0] y);
    days_in = MONTH_DAYS[m];
    if (m == MON_FEB && y[1:0] == 2'b00) begin
      days_in = 5'(MONTH_DAYS[m] + 5'h01);
    end
  endfunction : days_in

  // ----------------------------------------------------------------
  // Decode of the finished line
  // ----------------------------------------------------------------
  logic cmd_begin;
  logic cmd_finish;
  logic cmd_clear;
  logic cmd_set;
  logic cmd_get;
  logic [11:0] set_year;
  logic [3:0] set_mon;
  logic [4:0] set_day;
  logic [4:0] set_hour;
  logic [5:0] set_min;
  logic [5:0] set_sec;
  logic [7:0] rx_char;
  logic signed [31:0] smp;
  logic signed [31:0] smp_abs;
  logic signed [31:0] ind;

  assign cmd_begin = st_q.kw_len == LEN_BEGIN && st_q.kw == KW_BEGIN;
  assign cmd_finish = st_q.kw_len == LEN_FINISH && st_q.kw == KW_FINISH;
  assign cmd_clear = st_q.kw_len == LEN_CLEAR && st_q.kw == KW_CLEAR;
  assign cmd_set = st_q.kw_len == LEN_DATE && st_q.kw == KW_SETDATE;
  assign cmd_get = st_q.kw_len == LEN_DATE && st_q.kw == KW_GETDATE;
  // digits in order YYYY MM DD hh mm ss
  assign set_year = 12'(dig(st_q.digits, 0) * 1000 + dig(st_q.digits, 1) * 100 +
                        dig(st_q.digits, 2) * 10 + dig(st_q.digits, 3));
  assign set_mon = 4'(dig(st_q.digits, 4) * 10 + dig(st_q.digits, 5));
  assign set_day = 5'(dig(st_q.digits, 6) * 10 + dig(st_q.digits, 7));
  assign set_hour = 5'(dig(st_q.digits, 8) * 10 + dig(st_q.digits, 9));
  assign set_min = 6'(dig(st_q.digits, 10) * 10 + dig(st_q.digits, 11));
  assign set_sec = 6'(dig(st_q.digits, 12) * 10 + dig(st_q.digits, 13));
  assign rx_char = upcase(rx_data_i);
  assign smp = 32'(signed'(sample_i));
  assign smp_abs = (smp < 0) ? -smp : smp;
  assign ind = signed'(ind_value_i);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Replies are built whole before sending, so no request byte is taken while one drains
  always_comb begin
    st_d = st_q;
    st_d.clear = screen_reset_i;
    st_d.rated_ok = 1'b0;
    st_d.teds_sync = {st_q.teds_sync[0], teds_present_i};
    unique case (st_q.state)
      MCAL_RECV: begin
        if (rx_valid_i && st_q.rx_ready) begin
          // line end on either control character
          if (rx_char == CH_CR || rx_char == CH_LF) begin
            if (st_q.kw_len != 4'h0) begin
              st_d.state = MCAL_EXEC;
              st_d.rx_ready = 1'b0;
            end
          end else if (!st_q.in_arg) begin
            if (rx_char == CH_SP) begin
              st_d.in_arg = st_q.kw_len != 4'h0;
            end else if (st_q.kw_len < 4'(KW_BYTES)) begin
              st_d.kw = {st_q.kw[KW_W-9:0], rx_char};
              st_d.kw_len = st_q.kw_len + 4'h1;
            end else begin
              st_d.kw_len = 4'hF;
            end
          end else if (rx_char >= CH_ZERO && rx_char <= CH_NINE) begin
            st_d.arg_seen = 1'b1;
            if (st_q.dig_cnt < DATE_DIGITS) begin
              st_d.digits = {st_q.digits[DIG_W-5:0], rx_char[3:0]};
              st_d.dig_cnt = st_q.dig_cnt + 4'h1;
            end else begin
              st_d.bad_arg = 1'b1;
            end
          end else if (rx_char != CH_SP) begin
            st_d.arg_seen = 1'b1;
            st_d.bad_arg = st_q.bad_arg | (rx_char != CH_DOT && rx_char != CH_COLON);
          end
        end
      end
      MCAL_EXEC: begin
        st_d.state = MCAL_SEND;
        st_d.resp_len = 5'h00;
        // measurement commands need the measurement screen
        if (meas_screen_i && !st_q.arg_seen && (cmd_begin || cmd_finish || cmd_clear)) begin
          st_d.resp = {TXT_OK, CH_CR, CH_LF, 168'h0};
          st_d.resp_len = RLEN_OK;
          if (cmd_begin && st_q.active) begin
            st_d.resp = {TXT_ERR48, CH_CR, CH_LF, 136'h0};
            st_d.resp_len = RLEN_ERR;
          end else if (cmd_finish && !st_q.active) begin
            st_d.resp = {TXT_ERR48, CH_CR, CH_LF, 136'h0};
            st_d.resp_len = RLEN_ERR;
          end else if (cmd_begin) begin
            st_d.active = 1'b1;
          end else if (cmd_finish) begin
            st_d.active = 1'b0;
          end else begin
            st_d.clear = 1'b1;
          end
        end else if (cmd_set && st_q.dig_cnt == DATE_DIGITS && !st_q.bad_arg) begin
          st_d.year = set_year;
          st_d.mon = set_mon;
          st_d.day = set_day;
          st_d.hour = set_hour;
          st_d.min = set_min;
          st_d.sec = set_sec;
          st_d.tick = '0;
          st_d.resp = {TXT_OK, CH_CR, CH_LF, 168'h0};
          st_d.resp_len = RLEN_OK;
        end else if (cmd_get && !st_q.arg_seen) begin
          st_d.resp = {asc2(7'(st_q.year / 12'd100)), asc2(7'(st_q.year % 12'd100)), CH_DOT,
                       asc2(7'(st_q.mon)), CH_DOT, asc2(7'(st_q.day)), CH_SP,
                       asc2(7'(st_q.hour)), CH_COLON, asc2(7'(st_q.min)), CH_COLON,
                       asc2(7'(st_q.sec)), CH_CR, CH_LF, TXT_OK, CH_CR, CH_LF};
          st_d.resp_len = RLEN_DATE;
        end
        st_d.kw = '0;
        st_d.kw_len = 4'h0;
        st_d.in_arg = 1'b0;
        st_d.arg_seen = 1'b0;
        st_d.bad_arg = 1'b0;
        st_d.dig_cnt = 4'h0;
      end
      MCAL_SEND: begin
        // Byte stays put until the transmitter takes it
        if (!st_q.tx_valid || tx_ready_i) begin
          if (st_q.resp_len != 5'h00) begin
            st_d.tx_data = st_q.resp[RESP_W-1 -: 8];
            st_d.tx_valid = 1'b1;
            st_d.resp = {st_q.resp[RESP_W-9:0], 8'h00};
            st_d.resp_len = st_q.resp_len - 5'h01;
          end else begin
            st_d.tx_valid = 1'b0;
            st_d.state = MCAL_RECV;
            st_d.rx_ready = 1'b1;
          end
        end
      end
    endcase

    // Calendar; only a set-date that really loads overrides the fields, a refused one must not lose a tick
    if (!(st_q.state == MCAL_EXEC && cmd_set && st_q.dig_cnt == DATE_DIGITS && !st_q.bad_arg)) begin
      st_d.tick = (st_q.tick == TICK_LAST) ? '0 : TW'(st_q.tick + 1'b1);
      if (st_q.tick == TICK_LAST) begin
        st_d.sec = st_q.sec + 6'h01;
        if (st_q.sec >= MINSEC_MAX) begin
          st_d.sec = 6'h00;
          st_d.min = st_q.min + 6'h01;
          if (st_q.min >= MINSEC_MAX) begin
            st_d.min = 6'h00;
            st_d.hour = st_q.hour + 5'h01;
            if (st_q.hour >= HOUR_MAX) begin
              st_d.hour = 5'h00;
              st_d.day = st_q.day + 5'h01;
              if (st_q.day >= days_in(st_q.mon, st_q.year)) begin
                st_d.day = DAY_RST;
                st_d.mon = st_q.mon + 4'h1;
                if (st_q.mon >= MON_DEC) begin
                  st_d.mon = MON_RST;
                  st_d.year = st_q.year + 12'h001;
                end
              end
            end
          end
        end
      end
    end

    if (sample_valid_i) begin
      st_d.over_pos = smp > RANGE_LIM;
      st_d.over_neg = smp < -RANGE_LIM;
      st_d.err_range = cal_mode_i == MCAL_CAL_REAL && smp_abs > RANGE_LIM;
      st_d.err_zero = cal_mode_i == MCAL_CAL_REAL && cal_zero_step_i && smp_abs > ZERO_LIM;
    end
    if (cal_mode_i != MCAL_CAL_REAL) begin
      st_d.err_range = 1'b0;
      st_d.err_zero = 1'b0;
    end
    if (ind_valid_i) begin
      st_d.full_pos = ind > FULL_LIM;
      st_d.full_neg = ind < -FULL_LIM;
    end
    if (cal_mode_i != MCAL_CAL_EQUIV) begin
      st_d.err_over = 1'b0;
    end else if (rated_valid_i) begin
      st_d.err_over = rated_i > RATED_LIM;
      st_d.rated_ok = rated_i <= RATED_LIM;
    end
    st_d.err_teds = cal_mode_i == MCAL_CAL_TEDS && !st_q.teds_sync[1];
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= REGS_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign rx_ready_o = st_q.rx_ready;
  assign tx_data_o = st_q.tx_data;
  assign tx_valid_o = st_q.tx_valid;
  assign meas_active_o = st_q.active;
  assign meas_clear_o = st_q.clear;
  assign over_pos_o = st_q.over_pos;
  assign over_neg_o = st_q.over_neg;
  assign full_pos_o = st_q.full_pos;
  assign full_neg_o = st_q.full_neg;
  assign err_range_o = st_q.err_range;
  assign err_zero_o = st_q.err_zero;
  assign err_input_over_o = st_q.err_over;
  assign err_teds_o = st_q.err_teds;
  assign rated_accept_o = st_q.rated_ok;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  logic exec_meas;
  assign exec_meas = st_q.state == MCAL_EXEC && !st_q.arg_seen;

  property p_off_screen;
    exec_meas && !meas_screen_i && (cmd_begin || cmd_finish) |=> $stable(meas_active_o);
  endproperty
  a_off_screen: assert property (p_off_screen) else $error("command acted off screen");
  property p_begin_ok;
    exec_meas && meas_screen_i && cmd_begin && !meas_active_o |=> meas_active_o && st_q.resp_len == RLEN_OK;
  endproperty
  a_begin_ok: assert property (p_begin_ok) else $error("start did not begin");
  property p_begin_err;
    exec_meas && meas_screen_i && cmd_begin && meas_active_o |=> meas_active_o && st_q.resp_len == RLEN_ERR;
  endproperty
  a_begin_err: assert property (p_begin_err) else $error("start while running not refused");
  property p_finish_ok;
    exec_meas && meas_screen_i && cmd_finish && meas_active_o |=> !meas_active_o ##1 !meas_active_o;
  endproperty
  a_finish_ok: assert property (p_finish_ok) else $error("end did not stop");
  property p_finish_err;
    exec_meas && meas_screen_i && cmd_finish && !meas_active_o |=> st_q.resp_len == RLEN_ERR;
  endproperty
  a_finish_err: assert property (p_finish_err) else $error("end while idle not refused");
  property p_clear;
    exec_meas && meas_screen_i && cmd_clear |=> meas_clear_o && st_q.resp_len == RLEN_OK;
  endproperty
  a_clear: assert property (p_clear) else $error("reset gave no clear pulse");
  property p_set_date;
    st_q.state == MCAL_EXEC && cmd_set && st_q.dig_cnt == DATE_DIGITS && !st_q.bad_arg
      |=> st_q.year == $past(set_year) && st_q.sec == $past(set_sec) && st_q.mon == $past(set_mon);
  endproperty
  a_set_date: assert property (p_set_date) else $error("calendar not loaded");
  property p_get_date;
    exec_meas && cmd_get |=> st_q.resp_len == RLEN_DATE ##1 tx_valid_o;
  endproperty
  a_get_date: assert property (p_get_date) else $error("date reply missing");
  property p_over;
    sample_valid_i && smp > RANGE_LIM |=> over_pos_o && !over_neg_o;
  endproperty
  a_over: assert property (p_over) else $error("over-range not flagged");
  property p_full;
    ind_valid_i |=> full_pos_o == ($past(ind) > FULL_LIM) && full_neg_o == ($past(ind) < -FULL_LIM);
  endproperty
  a_full: assert property (p_full) else $error("overflow flags wrong");
  property p_zero;
    sample_valid_i && cal_mode_i == MCAL_CAL_REAL && cal_zero_step_i |=> err_zero_o == ($past(smp_abs) > ZERO_LIM);
  endproperty
  a_zero: assert property (p_zero) else $error("zero balance check wrong");
  property p_rated;
    rated_valid_i && cal_mode_i == MCAL_CAL_EQUIV && rated_i > RATED_LIM |=> err_input_over_o && !rated_accept_o;
  endproperty
  a_rated: assert property (p_rated) else $error("rated output not refused");
  property p_teds;
    cal_mode_i == MCAL_CAL_TEDS && !teds_present_i [*3] |=> err_teds_o;
  endproperty
  a_teds: assert property (p_teds) else $error("missing sensor not flagged");
  property p_line_end;
    st_q.state == MCAL_RECV && rx_valid_i && rx_ready_o && rx_data_i == CH_CR && st_q.kw_len != 4'h0
      |=> st_q.state == MCAL_EXEC && !rx_ready_o;
  endproperty
  a_line_end: assert property (p_line_end) else $error("line end not taken");
  property p_tx_hold;
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("reply byte dropped");

  c_lower: cover property (rx_valid_i && rx_ready_o && rx_data_i >= CH_LOW_A && rx_data_i <= CH_LOW_Z);
  c_err48: cover property (st_q.state == MCAL_EXEC ##1 st_q.resp_len == RLEN_ERR);
  c_get: cover property (st_q.state == MCAL_EXEC && cmd_get ##[1:40] st_q.state == MCAL_RECV);
  c_full: cover property (full_pos_o ##1 !full_pos_o);
endmodule : mcal_core
`default_nettype wire

// ### test/mcal_host.sv
`timescale 1ns/10ps
`default_nettype none
// Host computer at the far end of the serial link
module mcal_host (
  // Clock
  input wire logic clk_i,
  // Request bytes towards the block
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  // Reply bytes from the block
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o
);
  string got = "";
  bit slow = 0;
  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    tx_ready_o = 1'b1;
  end
  // Collect replies; slow mode stalls every other cycle
  always @(posedge clk_i) begin
    if (tx_valid_i === 1'b1 && tx_ready_o) got = {got, string'(tx_data_i)};
    #1 tx_ready_o = slow ? ~tx_ready_o : 1'b1;
  end
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      rx_data_o = s[i];
      rx_valid_o = 1'b1;
      @(posedge clk_i);
      while (rx_ready_i !== 1'b1) @(posedge clk_i);
      #1;
    end
    rx_valid_o = 1'b0;
    rx_data_o = ~rx_data_o; // Released line never shows the stale byte
  endtask : send
endmodule : mcal_host
`default_nettype wire

// ### test/test_mcal_core.sv
`timescale 1ns/10ps
`default_nettype none
module test_mcal_core;
  import mcal_pkg::*;
  logic clock_i = 0, rst_n_i = 0, rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i, meas_screen_i = 0;
  logic screen_reset_i = 0, meas_active_o, meas_clear_o, sample_valid_i = 0, ind_valid_i = 0;
  logic cal_zero_step_i = 0, rated_valid_i = 0, teds_present_i = 1, over_pos_o, over_neg_o;
  logic full_pos_o, full_neg_o, err_range_o, err_zero_o, err_input_over_o, err_teds_o, rated_accept_o;
  logic [7:0] rx_data_i, tx_data_o;
  logic [15:0] sample_i = 16'h0000, rated_i = 16'h0000;
  logic [31:0] ind_value_i = 32'h0000_0000;
  mcal_cal_t cal_mode_i = MCAL_CAL_NONE;
  int n_mismatch = 0, check_count = 0, cyc = 0, clr_seen = 0, acc_seen = 0;
  // Calendar tick of 50000 cycles outlasts the 20000-cycle hang guard, so the date replies never see a tick
  mcal_core #(.TICK_CYCLES(50000)) i_dut (.clk_i(clock_i), .rst_n_i(rst_n_i), .rx_data_i(rx_data_i),
    .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready_i), .meas_screen_i(meas_screen_i), .screen_reset_i(screen_reset_i),
    .meas_active_o(meas_active_o), .meas_clear_o(meas_clear_o), .sample_i(sample_i),
    .sample_valid_i(sample_valid_i), .ind_value_i(ind_value_i), .ind_valid_i(ind_valid_i),
    .cal_mode_i(cal_mode_i), .cal_zero_step_i(cal_zero_step_i), .rated_i(rated_i),
    .rated_valid_i(rated_valid_i), .teds_present_i(teds_present_i), .over_pos_o(over_pos_o),
    .over_neg_o(over_neg_o), .full_pos_o(full_pos_o), .full_neg_o(full_neg_o), .err_range_o(err_range_o),
    .err_zero_o(err_zero_o), .err_input_over_o(err_input_over_o), .err_teds_o(err_teds_o),
    .rated_accept_o(rated_accept_o));
  mcal_host i_host (.clk_i(clock_i), .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i), .rx_ready_i(rx_ready_o),
    .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i));
  // Clock, pulse counters and hang guard
  always #10 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc++;
    if (meas_clear_o === 1'b1) clr_seen++;
    if (rated_accept_o === 1'b1) acc_seen++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic chk(input bit ok, input string m);
    check_count++;
    if (!ok) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  // Keyword text rebuilt from the package constants, optionally folded to lower case
  function automatic string kw_text(input logic [71:0] k, input bit lc);
    logic [7:0] c;
    kw_text = "";
    for (int i = 8; i >= 0; i--) begin
      c = k[8*i +: 8];
      if (lc && c inside {[8'h41:8'h5A]}) c = c | CH_CASE_BIT;
      if (c != 8'h00) kw_text = {kw_text, string'(c)};
    end
  endfunction : kw_text
  // Send one line and compare the whole reply; an empty reply means none
  task automatic line(input string s, input string e);
    i_host.got = "";
    i_host.send(s);
    for (int n = 0; n < 400 && i_host.got.len() < e.len(); n++) @(posedge clock_i);
    repeat (8) @(posedge clock_i);
    #1 chk(i_host.got == e, {"reply to ", s});
  endtask : line
  task automatic smp(input logic [15:0] v, input logic [3:0] e);
    sample_i = v;
    sample_valid_i = 1'b1;
    @(posedge clock_i);
    #1 sample_valid_i = 1'b0;
    @(posedge clock_i);
    #1 chk({over_pos_o, over_neg_o, err_range_o, err_zero_o} === e, "sensor flags");
  endtask : smp
  task automatic ind(input logic [31:0] v, input logic [1:0] e);
    ind_value_i = v;
    ind_valid_i = 1'b1;
    @(posedge clock_i);
    #1 ind_valid_i = 1'b0;
    @(posedge clock_i);
    #1 chk({full_pos_o, full_neg_o} === e, "overflow flags");
  endtask : ind
  task automatic rated(input logic [15:0] v);
    rated_i = v;
    rated_valid_i = 1'b1;
    @(posedge clock_i);
    #1 rated_valid_i = 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
  endtask : rated
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  // Main sequence: commands, date, alarms, calibration
  initial begin
    repeat (20) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    @(posedge clock_i);
    #1 line({kw_text(KW_BEGIN, 0), "\r"}, "");
    chk(meas_active_o === 1'b0, "off screen start");
    meas_screen_i = 1'b1;
    i_host.slow = 1;
    line({kw_text(KW_BEGIN, 1), "\r"}, "OK\r\n");
    chk(meas_active_o === 1'b1, "active after start");
    i_host.slow = 0;
    line({kw_text(KW_BEGIN, 0), "\n"}, "ERR-48\r\n");
    line({kw_text(KW_CLEAR, 0), "\r"}, "OK\r\n");
    chk(clr_seen == 1 && meas_active_o === 1'b1, "reset pulse");
    // The screen button must give the same single clear pulse
    screen_reset_i = 1'b1;
    @(posedge clock_i);
    #1 screen_reset_i = 1'b0;
    repeat (2) @(posedge clock_i);
    #1 chk(clr_seen == 2 && meas_active_o === 1'b1, "screen reset pulse");
    line({kw_text(KW_FINISH, 0), "\r\n"}, "OK\r\n");
    chk(meas_active_o === 1'b0, "idle after end");
    line({kw_text(KW_FINISH, 0), "\r"}, "ERR-48\r\n");
    line("SET_DATE 2008.10.01 01:30:00\r", "OK\r\n");
    line("GET_DATE\r", "2008.10.01 01:30:00\r\nOK\r\n");
    smp(16'h7FF9, 4'b1000);
    smp(16'h7FF8, 4'b0000);
    smp(16'h8007, 4'b0100);
    ind(32'h0000_2710, 2'b10);
    ind(32'h0000_270F, 2'b00);
    ind(32'hFFFF_D8F0, 2'b01);
    cal_mode_i = MCAL_CAL_REAL;
    smp(16'h8007, 4'b0110);
    cal_zero_step_i = 1'b1;
    smp(16'hAAAF, 4'b0001);
    smp(16'h5550, 4'b0000);
    cal_mode_i = MCAL_CAL_EQUIV;
    rated(16'h0BB9);
    chk(err_input_over_o === 1'b1 && acc_seen == 0, "rated too big");
    rated(16'h0BB8);
    chk(err_input_over_o === 1'b0 && acc_seen == 1, "rated accepted");
    cal_mode_i = MCAL_CAL_TEDS;
    teds_present_i = 1'b0;
    repeat (4) @(posedge clock_i);
    #1 chk(err_teds_o === 1'b1, "teds missing");
    teds_present_i = 1'b1;
    repeat (4) @(posedge clock_i);
    #1 chk(err_teds_o === 1'b0, "teds present");
    // Mid-run reset drops the running measurement and restarts the calendar
    line({kw_text(KW_BEGIN, 0), "\r"}, "OK\r\n");
    rst_n_i = 1'b0;
    repeat (2) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    chk(meas_active_o === 1'b0 && rx_ready_o === 1'b1, "state after reset");
    line("GET_DATE\r", "2000.01.01 00:00:00\r\nOK\r\n");
    final_report();
  end
endmodule : test_mcal_core
`default_nettype wire
